// >>> core/fault_supervisor_pkg.sv
// Shared constants and types for the LED driver fault supervisor
package fault_supervisor_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned FAULT_TIME_US = 3600;
   localparam int unsigned FAULT_CYCLES = (FAULT_TIME_US * (CLK_HZ / 1000000));
   localparam int unsigned SOFT_START_US = 1000;
   localparam int unsigned SOFT_START_CYCLES = (SOFT_START_US * (CLK_HZ / 1000000));
   localparam int unsigned OSC_DIV = 20;
   localparam int unsigned CHANNELS = 2;

   // ---------------------------------------------------------------
   // Channel states
   // ---------------------------------------------------------------
   typedef enum logic [4:0]
   {
      CH_OFF = 5'h01,
      CH_SOFT = 5'h02,
      CH_RUN = 5'h04,
      CH_TIMER = 5'h08,
      CH_THERM = 5'h10
   } ch_state_e;

   // Device modes
   typedef enum logic [2:0]
   {
      MODE_POR = 3'h1,
      MODE_RUN = 3'h2,
      MODE_SLEEP = 3'h4
   } dev_mode_e;
endpackage : fault_supervisor_pkg

// >>> core/channel_if.sv
// Interface carrying one channel's comparator inputs and switch controls
`timescale 1ns/1ps
`default_nettype none
interface channel_if;
   logic enable;
   logic osc_tick;
   logic thermal_trip;
   logic thermal_cool;
   logic hs_limit;
   logic ls_limit;
   logic bst_uv;
   logic vin_uvlo;
   logic vin_dropout;
   logic comp_ov;
   logic short_det;
   logic hs_on;
   logic ls_force;
   logic switching;
   logic comp_discharge;
   logic err_amp_en;
   logic soft_start;
   logic fault_flag_n;
   modport sup (input enable, osc_tick, thermal_trip, thermal_cool, hs_limit, ls_limit, bst_uv,
      vin_uvlo, vin_dropout, comp_ov, short_det);
   modport ch (input enable, osc_tick, thermal_trip, thermal_cool, hs_limit, ls_limit, bst_uv,
      vin_uvlo, vin_dropout, comp_ov, short_det, output hs_on, ls_force, switching, comp_discharge,
      err_amp_en, soft_start, fault_flag_n);
endinterface : channel_if
`default_nettype wire

// >>> core/osc_divider.sv
// Internal oscillator tick divider
`timescale 1ns/1ps
`default_nettype none
module osc_divider
   import fault_supervisor_pkg::*;
#(
   parameter int unsigned DIV = OSC_DIV
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic run_i,
   output logic tick_o
);
   logic [7:0] cnt_q;

   // Count is held at zero when the oscillator is off so sleep burns nothing
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 8'h00;
         tick_o <= 1'b0;
      end
      else if (!run_i)
      begin
         cnt_q <= 8'h00;
         tick_o <= 1'b0;
      end
      else if (cnt_q == 8'(DIV - 1))
      begin
         cnt_q <= 8'h00;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 8'h01;
         tick_o <= 1'b0;
      end
   end
endmodule : osc_divider
`default_nettype wire

// >>> core/channel_fsm.sv
// One channel's fault state, fault timer and switch control
`timescale 1ns/1ps
`default_nettype none
module channel_fsm
   import fault_supervisor_pkg::*;
#(
   parameter int unsigned FAULT_TICKS = FAULT_CYCLES / OSC_DIV,
   parameter int unsigned SOFT_TICKS = SOFT_START_CYCLES / OSC_DIV
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Channel bundle
   channel_if.ch bus
);
   ch_state_e state_q;
   logic [15:0] cnt_q;
   logic ilim;

   assign ilim = bus.hs_limit | bus.ls_limit;

   // Channel state; a fault here never touches the sibling channel
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= CH_OFF;
         cnt_q <= 16'h0000;
      end
      else if (!bus.enable)
      begin
         state_q <= CH_OFF;
         cnt_q <= 16'h0000;
      end
      else
      begin
         unique case (state_q)
            CH_OFF:
            begin
               cnt_q <= 16'h0000;
               if (!bus.vin_uvlo && !bus.thermal_trip && !ilim)
                  state_q <= CH_SOFT;
            end
            CH_SOFT, CH_RUN:
            begin
               if (bus.thermal_trip)
                  state_q <= CH_THERM;
               else if (ilim)
               begin
                  state_q <= CH_TIMER;
                  cnt_q <= 16'h0000;
               end
               else if (bus.vin_uvlo)
                  state_q <= CH_OFF;
               else if (state_q == CH_SOFT && bus.osc_tick)
               begin
                  if (cnt_q == 16'(SOFT_TICKS - 1))
                     state_q <= CH_RUN;
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            CH_TIMER:
            begin
               // Timer runs on oscillator ticks; expiry restarts through soft-start
               if (bus.osc_tick)
               begin
                  if (cnt_q == 16'(FAULT_TICKS - 1))
                  begin
                     state_q <= CH_SOFT;
                     cnt_q <= 16'h0000;
                  end
                  else
                     cnt_q <= cnt_q + 16'h0001;
               end
            end
            CH_THERM:
            begin
               if (bus.thermal_cool && !bus.thermal_trip)
               begin
                  state_q <= CH_SOFT;
                  cnt_q <= 16'h0000;
               end
            end
            default:
               state_q <= CH_OFF;
         endcase
      end
   end

   // Switch drive; high-side limit turns low side on, low-side limit turns both off
   always_comb
   begin
      bus.switching = (state_q == CH_SOFT || state_q == CH_RUN) && !bus.vin_uvlo;
      bus.soft_start = (state_q == CH_SOFT);
      bus.hs_on = bus.switching && !bus.bst_uv && !ilim;
      bus.ls_force = bus.switching && (bus.bst_uv || (bus.hs_limit && !bus.ls_limit));
      bus.comp_discharge = !bus.switching || ilim;
      bus.err_amp_en = bus.switching && !bus.vin_dropout;
      // Only open and short diagnoses pull the flag
      bus.fault_flag_n = !(bus.enable && (bus.comp_ov || bus.short_det));
   end
endmodule : channel_fsm
`default_nettype wire

// >>> core/led_driver_fault_supervisor.sv
// Top of the dual-channel LED driver fault and mode supervisor
// Functional notes
// - Thermal trip or either current limit triggers automatic restart.
// - Thermal restart only after the cool-down hysteresis comparator reports recovery.
// - Every restart passes through soft-start before switching resumes.
// - Current limit starts the fault timer; expiry restarts the channel.
// - Fault flag goes low only for open or short output.
// - Input dropout only disables the error amplifier: no timer, no flag.
// - Input undervoltage stops switching without timer or flag.
// - Bootstrap undervoltage starts no timer and sets no flag.
// - Output short comparator drives that channel's fault flag low.
// - An output short never disables switching.
// - Compensation overvoltage drives the fault flag low as open load.
// - Either supply undervoltage holds both channels off in reset state.
// - Reset state ends when the gate-drive supply is good and the analog supply is not undervoltage.
// - Enable high gives run mode; preconditions checked before soft-start.
// - A current-limit fault in run mode waits for the fault timer.
// - Enable low enters sleep mode.
// - Sleep disconnects regulators, stops oscillator, turns all switches off.
// - Thermal trip shuts down only the affected channel.
// - High-side limit: high side off, low side on, comp discharged.
// - Low-side limit: both switches off, comp discharged.
// - Bootstrap undervoltage: high side off, low side on until recovery.
`timescale 1ns/1ps
`default_nettype none
module led_driver_fault_supervisor
   import fault_supervisor_pkg::*;
#(
   parameter int unsigned FAULT_TICKS = FAULT_CYCLES / OSC_DIV,
   parameter int unsigned SOFT_TICKS = SOFT_START_CYCLES / OSC_DIV
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Supplies and enable
   input wire logic gate_drive_supply_good_i,
   input wire logic analog_supply_undervoltage_i,
   input wire logic enable_i,
   // Per-channel comparator inputs
   input wire logic [1:0] thermal_trip_i,
   input wire logic [1:0] thermal_cool_i,
   input wire logic [1:0] high_side_limit_fault_i,
   input wire logic [1:0] low_side_limit_fault_i,
   input wire logic [1:0] bootstrap_undervoltage_fault_i,
   input wire logic [1:0] input_undervoltage_fault_i,
   input wire logic [1:0] input_dropout_diag_i,
   input wire logic [1:0] comp_overvoltage_diag_i,
   input wire logic [1:0] output_short_diag_i,
   // Mode outputs
   output logic por_o,
   output logic run_mode_o,
   output logic sleep_o,
   output logic regulators_on_o,
   output logic osc_run_o,
   // Per-channel controls
   output logic [1:0] hs_on_o,
   output logic [1:0] ls_on_o,
   output logic [1:0] switching_o,
   output logic [1:0] comp_discharge_o,
   output logic [1:0] err_amp_en_o,
   output logic [1:0] soft_start_o,
   // Open-drain fault flags: low level only in run mode
   output logic [1:0] fault_flag_n_o,
   output logic [1:0] fault_flag_n_oe_o
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;

   // Release is synchronised so no flop leaves reset on a partial edge
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Device mode
   // ---------------------------------------------------------------
   dev_mode_e mode_q;
   logic supply_bad;

   assign supply_bad = !gate_drive_supply_good_i || analog_supply_undervoltage_i;

   // Supply loss overrides enable in every mode
   always_ff @(posedge ref_clk_i or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
         mode_q <= MODE_POR;
      else if (supply_bad)
         mode_q <= MODE_POR;
      else if (enable_i)
         mode_q <= MODE_RUN;
      else
         mode_q <= MODE_SLEEP;
   end

   // ---------------------------------------------------------------
   // Oscillator and channels
   // ---------------------------------------------------------------
   logic tick;
   logic osc_en;

   assign osc_en = (mode_q == MODE_RUN);

   osc_divider #(.DIV(OSC_DIV)) u_osc
   (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_s2_q),
      .run_i(osc_en),
      .tick_o(tick)
   );

   logic [1:0] hs_w;
   logic [1:0] ls_w;
   logic [1:0] sw_w;
   logic [1:0] cd_w;
   logic [1:0] ea_w;
   logic [1:0] ss_w;
   logic [1:0] ff_w;

   // Two independent channel instances share nothing but the tick and the run-mode enable
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      channel_if cif();
      assign cif.enable = osc_en;
      assign cif.osc_tick = tick;
      assign cif.thermal_trip = thermal_trip_i[c];
      assign cif.thermal_cool = thermal_cool_i[c];
      assign cif.hs_limit = high_side_limit_fault_i[c];
      assign cif.ls_limit = low_side_limit_fault_i[c];
      assign cif.bst_uv = bootstrap_undervoltage_fault_i[c];
      assign cif.vin_uvlo = input_undervoltage_fault_i[c];
      assign cif.vin_dropout = input_dropout_diag_i[c];
      assign cif.comp_ov = comp_overvoltage_diag_i[c];
      assign cif.short_det = output_short_diag_i[c];
      channel_fsm #(.FAULT_TICKS(FAULT_TICKS), .SOFT_TICKS(SOFT_TICKS)) u_ch
      (
         .clk_i(ref_clk_i),
         .rst_n_i(rst_s2_q),
         .bus(cif)
      );
      assign hs_w[c] = cif.hs_on;
      assign ls_w[c] = cif.ls_force;
      assign sw_w[c] = cif.switching;
      assign cd_w[c] = cif.comp_discharge;
      assign ea_w[c] = cif.err_amp_en;
      assign ss_w[c] = cif.soft_start;
      assign ff_w[c] = cif.fault_flag_n;
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   // Mode outputs
   always_ff @(posedge ref_clk_i or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         por_o <= 1'b1;
         run_mode_o <= 1'b0;
         sleep_o <= 1'b0;
         regulators_on_o <= 1'b0;
         osc_run_o <= 1'b0;
      end
      else
      begin
         por_o <= (mode_q == MODE_POR);
         run_mode_o <= (mode_q == MODE_RUN);
         sleep_o <= (mode_q == MODE_SLEEP);
         regulators_on_o <= (mode_q != MODE_SLEEP);
         osc_run_o <= osc_en;
      end
   end

   // Channel outputs; one cycle of latency is far below any analog reaction time
   always_ff @(posedge ref_clk_i or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         hs_on_o <= 2'h0;
         ls_on_o <= 2'h0;
         switching_o <= 2'h0;
         comp_discharge_o <= 2'h3;
         err_amp_en_o <= 2'h0;
         soft_start_o <= 2'h0;
         fault_flag_n_o <= 2'h3;
         fault_flag_n_oe_o <= 2'h0;
      end
      else
      begin
         hs_on_o <= hs_w;
         ls_on_o <= ls_w;
         switching_o <= sw_w;
         comp_discharge_o <= cd_w;
         err_amp_en_o <= ea_w;
         soft_start_o <= ss_w;
         fault_flag_n_o <= ff_w;
         fault_flag_n_oe_o <= ~ff_w;
      end
   end
endmodule : led_driver_fault_supervisor
`default_nettype wire

// >>> bench/fault_supervisor_props.sv
// Concurrent checks on the fault supervisor top-level ports
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor_props
   import fault_supervisor_pkg::*;
#(
   parameter int unsigned FAULT_TICKS = 5,
   parameter int unsigned SOFT_TICKS = 3
)
(
   // Clock, reset and supplies
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic gate_drive_supply_good_i,
   input wire logic analog_supply_undervoltage_i,
   input wire logic enable_i,
   // Channel comparators
   input wire logic [1:0] thermal_trip_i,
   input wire logic [1:0] high_side_limit_fault_i,
   input wire logic [1:0] low_side_limit_fault_i,
   input wire logic [1:0] bootstrap_undervoltage_fault_i,
   input wire logic [1:0] input_undervoltage_fault_i,
   input wire logic [1:0] comp_overvoltage_diag_i,
   input wire logic [1:0] output_short_diag_i,
   // Watched outputs
   input wire logic por_o,
   input wire logic run_mode_o,
   input wire logic sleep_o,
   input wire logic regulators_on_o,
   input wire logic osc_run_o,
   input wire logic [1:0] hs_on_o,
   input wire logic [1:0] ls_on_o,
   input wire logic [1:0] switching_o,
   input wire logic [1:0] comp_discharge_o,
   input wire logic [1:0] soft_start_o,
   input wire logic [1:0] fault_flag_n_o
);
   // ----------------------------------------
   // Mode and channel properties
   // ----------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Conditions that may legally stop channel 0
   wire logic sup_bad = !gate_drive_supply_good_i || analog_supply_undervoltage_i;
   wire logic [1:0] stop = thermal_trip_i | high_side_limit_fault_i | low_side_limit_fault_i |
      bootstrap_undervoltage_fault_i | input_undervoltage_fault_i;
   wire logic quiet0 = !sup_bad && enable_i && !stop[0];
   wire logic live0 = switching_o[0] && run_mode_o && !thermal_trip_i[0] && !input_undervoltage_fault_i[0];
   sequence held_bad; sup_bad[*6]; endsequence
   sequence held_run; (!sup_bad && enable_i)[*6]; endsequence
   sequence held_sleep; (!sup_bad && !enable_i)[*6]; endsequence
   logic [15:0] off_cnt_q;
   logic limit_seen_q;
   // Off time since a limit hit; the timer must run out before soft-start
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         off_cnt_q <= 16'h0;
         limit_seen_q <= 1'b0;
      end
      else if (live0 && (high_side_limit_fault_i[0] || low_side_limit_fault_i[0]))
      begin
         off_cnt_q <= 16'h0;
         limit_seen_q <= 1'b1;
      end
      else
      begin
         off_cnt_q <= off_cnt_q + 16'h1;
         limit_seen_q <= limit_seen_q && !soft_start_o[0];
      end
   end
   por_hold_a: assert property (held_bad |-> por_o && !run_mode_o && (switching_o | hs_on_o) == 2'h0)
      else $error("channels not held off with a supply bad");
   run_entry_a: assert property (held_run |-> run_mode_o && !por_o && !sleep_o)
      else $error("run mode not entered");
   sleep_state_a: assert property (held_sleep |-> sleep_o && !osc_run_o && !regulators_on_o &&
      (hs_on_o | ls_on_o | switching_o) == 2'h0) else $error("sleep state incomplete");
   flag_quiet_a: assert property (
      ((comp_overvoltage_diag_i | output_short_diag_i) == 2'h0)[*3] |-> fault_flag_n_o == 2'h3)
      else $error("flag low without open or short");
   flag_diag_a: assert property (
      (run_mode_o && (comp_overvoltage_diag_i[0] || output_short_diag_i[0]))[*3] |-> !fault_flag_n_o[0])
      else $error("flag not low on open or short");
   short_run_a: assert property (quiet0[*3] ##1 (quiet0 && switching_o[0]) ##1 quiet0 |-> switching_o[0])
      else $error("switching stopped without a stopping fault");
   hs_limit_a: assert property (live0 && high_side_limit_fault_i[0] && !low_side_limit_fault_i[0]
      |-> ##[1:2] (!hs_on_o[0] && ls_on_o[0] && comp_discharge_o[0])) else $error("high-side limit response");
   ls_limit_a: assert property (live0 && low_side_limit_fault_i[0] && !high_side_limit_fault_i[0]
      |-> ##[1:2] (!hs_on_o[0] && !ls_on_o[0] && comp_discharge_o[0])) else $error("low-side limit response");
   restart_wait_a: assert property (limit_seen_q && $rose(soft_start_o[0])
      |-> off_cnt_q >= (FAULT_TICKS - 1) * OSC_DIV) else $error("restart before fault timer expiry");
   bst_uv_a: assert property ((live0 && bootstrap_undervoltage_fault_i[0] && !stop[0] == 1'b0 &&
      !high_side_limit_fault_i[0] && !low_side_limit_fault_i[0])[*3] |-> !hs_on_o[0] && ls_on_o[0])
      else $error("bootstrap undervoltage switch state");
endmodule : fault_supervisor_props
bind led_driver_fault_supervisor fault_supervisor_props #(.FAULT_TICKS(FAULT_TICKS), .SOFT_TICKS(SOFT_TICKS))
   i_props (.*);
`default_nettype wire

// >>> bench/fault_flag_reader.sv
// Controller side of the open-drain fault flag lines
`timescale 1ns/1ps
`default_nettype none
module fault_flag_reader
(
   // Open-drain enables from the device
   input wire logic [1:0] fault_flag_n_oe_o,
   // Levels read by the controller
   output logic [1:0] flag_level_o
);
   // ----------------------------------------
   // Line resolution
   // ----------------------------------------
   // External pull-up wins whenever the device lets go, so a released line never floats
   assign flag_level_o = ~fault_flag_n_oe_o;
endmodule : fault_flag_reader
`default_nettype wire

// >>> bench/test_led_driver_fault_supervisor.sv
// Self-checking bench for the LED driver fault supervisor
`timescale 1ns/1ps
`default_nettype none
module test_led_driver_fault_supervisor
   import fault_supervisor_pkg::*;
;
   // ----------------------------------------
   // Stimulus, model and checks
   // ----------------------------------------
   localparam int FT = 5;
   localparam int ST = 3;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, gate_drive_supply_good_i = 1'b0;
   logic analog_supply_undervoltage_i = 1'b0, enable_i = 1'b0;
   logic [1:0] thermal_trip_i = 2'h0, thermal_cool_i = 2'h0, high_side_limit_fault_i = 2'h0;
   logic [1:0] low_side_limit_fault_i = 2'h0, bootstrap_undervoltage_fault_i = 2'h0;
   logic [1:0] input_undervoltage_fault_i = 2'h0, input_dropout_diag_i = 2'h0;
   logic [1:0] comp_overvoltage_diag_i = 2'h0, output_short_diag_i = 2'h0;
   logic por_o, run_mode_o, sleep_o, regulators_on_o, osc_run_o;
   logic [1:0] hs_on_o, ls_on_o, switching_o, comp_discharge_o, err_amp_en_o, soft_start_o;
   logic [1:0] fault_flag_n_o, fault_flag_n_oe_o, flag_level, e;
   int mismatches = 0, checks = 0, seed = 32'h34799873, c, n;
   always #25 ref_clk_i = ~ref_clk_i;
   led_driver_fault_supervisor #(.FAULT_TICKS(FT), .SOFT_TICKS(ST)) i_dut (.*);
   fault_flag_reader i_reader (.fault_flag_n_oe_o(fault_flag_n_oe_o), .flag_level_o(flag_level));
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask : cyc
   // Bounded wait: sel 0 soft-start seen, sel 1 switching after soft-start; count must land in [lo,hi]
   task automatic wt(input int sel, input int ch, input int lo, input int hi);
      int k;
      k = 0;
      while (k <= hi && !(sel ? (switching_o[ch] === 1'b1 && soft_start_o[ch] === 1'b0) : soft_start_o[ch] === 1'b1))
      begin
         cyc(1);
         k++;
      end
      chk(k >= lo && k <= hi, 1);
      if (k > hi)
         close_out();
   endtask : wt
   // Fault input selected by index, driven off the sampling edge
   task automatic put(input int i, input int ch, input logic v);
      case (i)
         0: bootstrap_undervoltage_fault_i[ch] = v;
         1: input_undervoltage_fault_i[ch] = v;
         2: input_dropout_diag_i[ch] = v;
         3: comp_overvoltage_diag_i[ch] = v;
         4: output_short_diag_i[ch] = v;
         5: high_side_limit_fault_i[ch] = v;
         default: low_side_limit_fault_i[ch] = v;
      endcase
   endtask : put
   // Main sequence: reset, modes, diagnostics, limits, thermal, sleep
   initial
   begin
      cyc(4);
      chk({por_o, comp_discharge_o, fault_flag_n_o, switching_o}, 32'h7c);
      cyc(4);
      rst_n_i = 1'b1;
      cyc(8);
      chk({por_o, switching_o}, 32'h4);
      gate_drive_supply_good_i = 1'b1;
      analog_supply_undervoltage_i = 1'b1;
      cyc(6);
      chk(por_o, 1);
      analog_supply_undervoltage_i = 1'b0;
      cyc(6);
      chk({por_o, sleep_o}, 1);
      // One enable edge starts both channels at once, as paralleled channels need
      enable_i = 1'b1;
      wt(0, 0, 1, 30);
      wt(1, 0, (ST - 1) * OSC_DIV, (ST + 1) * OSC_DIV + 5);
      cyc(3);
      chk({run_mode_o, osc_run_o, regulators_on_o, switching_o}, 32'h1f);
      $display("startup test done");
      for (int i = 0; i < 5; i++)
      begin
         c = $random(seed) & 1;
         put(i, c, 1'b1);
         cyc(4);
         // Model: only the open and short diagnostics pull a flag low
         e = (i > 2) ? ~(2'h1 << c) : 2'h3;
         chk(fault_flag_n_o, e);
         chk(flag_level, e);
         chk(switching_o, (i == 1) ? 2'h3 ^ (2'h1 << c) : 2'h3);
         chk(err_amp_en_o, (i == 1 || i == 2) ? 2'h3 ^ (2'h1 << c) : 2'h3);
         if (i == 0)
            chk({hs_on_o[c], ls_on_o[c]}, 1);
         put(i, c, 1'b0);
         if (i == 1)
         begin
            wt(0, c, 1, 30);
            wt(1, c, (ST - 1) * OSC_DIV, (ST + 1) * OSC_DIV + 5);
         end
         cyc(4);
      end
      // Common dimming pulse on both input lines; soft-starts must stay aligned
      input_undervoltage_fault_i = 2'h3;
      cyc(4);
      chk(switching_o, 2'h0);
      input_undervoltage_fault_i = 2'h0;
      wt(0, 1, 1, 30);
      chk(soft_start_o, 2'h3);
      wt(1, 1, (ST - 1) * OSC_DIV, (ST + 1) * OSC_DIV + 5);
      $display("diagnostic test done");
      for (int k = 5; k < 7; k++)
      begin
         put(k, 0, 1'b1);
         cyc(1);
         // The low-side pulse lasts only while the limit is seen in a switching state
         chk({hs_on_o[0], ls_on_o[0], comp_discharge_o[0], switching_o[1]},
            (k == 5) ? 4'h7 : 4'h3);
         put(k, 0, 1'b0);
         cyc(2);
         chk({switching_o[0], comp_discharge_o[0]}, 1);
         wt(0, 0, (FT - 1) * OSC_DIV - 4, (FT + 1) * OSC_DIV);
         wt(1, 0, (ST - 1) * OSC_DIV, (ST + 1) * OSC_DIV + 5);
      end
      $display("limit test done");
      n = 20 + ($random(seed) & 31);
      thermal_trip_i[1] = 1'b1;
      cyc(4);
      chk(switching_o, 2'h1);
      thermal_trip_i[1] = 1'b0;
      cyc(n);
      chk(switching_o, 2'h1);
      thermal_cool_i[1] = 1'b1;
      wt(0, 1, 1, 30);
      wt(1, 1, (ST - 1) * OSC_DIV, (ST + 1) * OSC_DIV + 5);
      thermal_cool_i[1] = 1'b0;
      $display("thermal test done");
      enable_i = 1'b0;
      cyc(5);
      chk({sleep_o, osc_run_o, regulators_on_o, hs_on_o, ls_on_o, switching_o}, 32'h100);
      gate_drive_supply_good_i = 1'b0;
      enable_i = 1'b1;
      cyc(5);
      chk({por_o, run_mode_o, switching_o}, 32'h8);
      $display("mode test done");
      close_out();
   end
endmodule : test_led_driver_fault_supervisor
`default_nettype wire
